/* logic/twe_dev.sv */
// memory device end: link logic on the serial clock, write timer on the core clock
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RQ1: data changes only while clock low
// RQ2: data fall with clock high starts transfer
// RQ3: data rise with clock high stops; standby
// RQ4: bytes of eight; acknowledge on ninth clock
// RQ5: host acknowledge continues read; else standby (code drops to S_IDLE, standby rises only at the next stop)
// RQ6: standby at power-up and after stop
// RQ7: host recovers with nine clocks, start
// RQ8: address word top nibble must be 1010
// RQ9: next three bits are upper word address
// RQ10: lowest address bit selects read or write
// RQ11: match acknowledges; mismatch releases, goes idle
// RQ12: byte write: address, word address, data, stop
// RQ13: stop launches program cycle, inputs ignored
// RQ14: page write takes up to page size
// RQ15: page write advances low bits, wraps page
// RQ16: polling acknowledged only after programming ends
// RQ17: address counter holds last address plus one
// RQ18: reads wrap whole memory, writes wrap page
// RQ19: current read sends byte at counter
// RQ20: random read: dummy write, repeated start
// RQ21: sequential read continues while host acknowledges
// RQ22: sample on rising, drive after falling edge
// RQ23: data line only pulled low or released
// RQ24: density parameter sets widths and page
module twe_dev import twe_pkg::*; #(
  parameter int DENSITY_KBIT = DEFAULT_DENSITY_KBIT,
  parameter int PROG_CYCLES = SELF_TIMED_PROGRAM_CYCLES
) (
  twe_if.dev bus,
  input wire logic clock,
  input wire logic nrst,
  output logic standby,
  output logic prog_busy
);
  localparam int WA = $clog2(DENSITY_KBIT * WORDS_PER_KBIT); // RQ24
  localparam int PB = (DENSITY_KBIT <= SMALL_DENSITY_MAX_KBIT) ?
    SMALL_PAGE_BITS : LARGE_PAGE_BITS; // RQ24
  localparam int PAGE = 1 << PB;
  localparam int DEPTH = 1 << WA;
  localparam int TW = $clog2(PROG_CYCLES + 1);

  if (!(DENSITY_KBIT inside {1, 2, 4, 8, 16}) || PROG_CYCLES < 1) begin : g_bad_param
    $error("unsupported density or program time");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // start and stop detection on data edges while clock is high
  logic start_tog_r;
  logic stop_tog_r;

  always_ff @(negedge bus.sda or negedge nrst) begin
    if (!nrst) begin
      start_tog_r <= 1'b0;
    end else if (bus.scl) begin
      start_tog_r <= ~start_tog_r; // RQ1 RQ2
    end
  end

  always_ff @(posedge bus.sda or negedge nrst) begin
    if (!nrst) begin
      stop_tog_r <= 1'b0;
    end else if (bus.scl) begin
      stop_tog_r <= ~stop_tog_r; // RQ1 RQ3
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link side, serial clock domain
  twe_dev_state_t st_r;
  logic start_ack_r;
  logic stop_ack_r;
  logic [3:0] cnt_r;
  logic [6:0] sh_r;
  logic dir_r;
  logic [2:0] up_r;
  logic [WA-1:0] addr_r;
  logic [7:0] rd_r;
  logic ack_r;
  logic armed_r;
  logic prog_r;
  logic done_ack_r;
  logic [1:0] done_sync_r;
  logic [PAGE-1:0] mask_r;
  logic oe_n_r;
  logic done_tog_r;
  logic [7:0] pbuf [PAGE];
  logic [7:0] mem [DEPTH];

  logic new_frame;
  logic [3:0] idx;
  logic [7:0] byte_in;
  logic dev_match;
  logic commit;
  logic [10:0] wa_full;

  assign new_frame = start_tog_r != start_ack_r;
  assign idx = new_frame ? 4'h0 : cnt_r;
  assign byte_in = {sh_r, bus.sda};
  assign dev_match = byte_in[7:DEV_TYPE_LSB] == DEV_TYPE_CODE && !prog_r; // RQ8 RQ16
  assign commit = prog_r && (done_sync_r[1] != done_ack_r);
  assign wa_full = {up_r, byte_in}; // RQ9

  // bit counter, shifter and protocol state; bits sampled on rising edge
  always_ff @(posedge bus.scl or negedge nrst) begin
    if (!nrst) begin
      st_r <= S_IDLE;
      start_ack_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 7'h00;
      dir_r <= 1'b0;
      up_r <= 3'h0;
      ack_r <= 1'b0;
    end else begin
      start_ack_r <= start_tog_r;
      cnt_r <= (idx == ACK_CLOCK) ? 4'h0 : idx + 4'h1; // RQ4 RQ22
      sh_r <= byte_in[6:0];
      ack_r <= 1'b0;
      if (new_frame) begin
        st_r <= S_ADDR; // RQ2
      end else if (idx == LAST_DATA_BIT) begin
        case (st_r)
          S_ADDR: begin
            dir_r <= byte_in[RW_BIT_POS]; // RQ10
            up_r <= byte_in[UPPER_WORD_ADDR_BIT_HIGH_POS:UPPER_WORD_ADDR_BIT_LOW_POS]; // RQ9
            ack_r <= dev_match; // RQ4 RQ11
            if (!dev_match) begin
              st_r <= S_IDLE; // RQ11 RQ13
            end
          end
          S_WADDR: begin
            ack_r <= 1'b1; // RQ12
            st_r <= S_WDATA;
          end
          S_WDATA: begin
            ack_r <= 1'b1; // RQ14
          end
          default: ;
        endcase
      end else if (idx == ACK_CLOCK) begin
        case (st_r)
          S_ADDR: begin
            st_r <= dir_r ? S_READ : S_WADDR; // RQ10
          end
          S_READ: begin
            if (bus.sda) begin
              st_r <= S_IDLE; // RQ5
            end
          end
          default: ;
        endcase
      end
    end
  end

  // word-address counter and read data
  always_ff @(posedge bus.scl or negedge nrst) begin
    if (!nrst) begin
      addr_r <= '0;
      rd_r <= 8'h00;
    end else if (!new_frame && idx == LAST_DATA_BIT) begin
      if (st_r == S_ADDR && dev_match && byte_in[RW_BIT_POS]) begin
        rd_r <= mem[addr_r]; // RQ19
        addr_r <= addr_r + 1'b1; // RQ17 RQ18
      end else if (st_r == S_WADDR) begin
        addr_r <= wa_full[WA-1:0]; // RQ9 RQ12 RQ20
      end else if (st_r == S_WDATA) begin
        addr_r <= {addr_r[WA-1:PB], addr_r[PB-1:0] + 1'b1}; // RQ15 RQ18
      end
    end else if (!new_frame && idx == ACK_CLOCK && st_r == S_READ && !bus.sda) begin
      rd_r <= mem[addr_r]; // RQ21
      addr_r <= addr_r + 1'b1; // RQ18 RQ21
    end
  end

  // write arming, program lock and page mask
  always_ff @(posedge bus.scl or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
      prog_r <= 1'b0;
      stop_ack_r <= 1'b0;
      done_ack_r <= 1'b0;
      mask_r <= '0;
    end else begin
      if (new_frame) begin
        stop_ack_r <= stop_tog_r;
        if (armed_r && !prog_r) begin
          if (stop_tog_r != stop_ack_r) begin
            prog_r <= 1'b1; // RQ13
          end else begin
            armed_r <= 1'b0;
            mask_r <= '0;
          end
        end
      end else if (idx == LAST_DATA_BIT && st_r == S_WADDR) begin
        mask_r <= '0;
      end else if (idx == LAST_DATA_BIT && st_r == S_WDATA) begin
        mask_r[addr_r[PB-1:0]] <= 1'b1; // RQ15
        armed_r <= 1'b1;
      end
      if (commit) begin
        prog_r <= 1'b0; // RQ16
        armed_r <= 1'b0;
        mask_r <= '0;
        done_ack_r <= done_sync_r[1];
      end
    end
  end

  // page buffer and array; the page lands once the program time is over
  always_ff @(posedge bus.scl) begin
    if (!new_frame && idx == LAST_DATA_BIT && st_r == S_WDATA) begin
      pbuf[addr_r[PB-1:0]] <= byte_in; // RQ14 RQ15
    end
    if (commit) begin
      for (int j = 0; j < PAGE; j++) begin
        if (mask_r[j]) begin
          mem[{addr_r[WA-1:PB], PB'(j)}] <= pbuf[j]; // RQ13
        end
      end
    end
  end

  always_ff @(posedge bus.scl or negedge nrst) begin
    if (!nrst) begin
      done_sync_r <= 2'b00;
    end else begin
      done_sync_r <= {done_sync_r[0], done_tog_r};
    end
  end

  // outgoing bits change after the falling edge, low drive only
  always_ff @(negedge bus.scl or negedge nrst) begin
    if (!nrst) begin
      oe_n_r <= 1'b1;
    end else if (new_frame) begin
      oe_n_r <= 1'b1; // RQ2 RQ23
    end else if (cnt_r == ACK_CLOCK) begin
      oe_n_r <= ~ack_r; // RQ4 RQ22 RQ23
    end else if (st_r == S_READ) begin
      oe_n_r <= rd_r[3'h7 - cnt_r[2:0]]; // RQ19 RQ22 RQ23
    end else begin
      oe_n_r <= 1'b1; // RQ23
    end
  end

  assign bus.dev_sda_oe_n = oe_n_r;
  assign bus.dev_sda_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // core clock domain: program timer and standby
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [1:0] prev_r;
  logic busy_r;
  logic wait_r;
  logic idle_r;
  logic standby_r;
  logic [TW-1:0] tmr_r;
  logic start_ev;
  logic stop_ev;
  logic launch;

  assign start_ev = sync2_r[0] != prev_r[0];
  assign stop_ev = sync2_r[1] != prev_r[1];
  assign launch = stop_ev && sync2_r[2] && !busy_r && !wait_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r <= 2'h0;
    end else begin
      sync1_r <= {armed_r, stop_tog_r, start_tog_r};
      sync2_r <= sync1_r;
      prev_r <= sync2_r[1:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      wait_r <= 1'b0;
      tmr_r <= '0;
      done_tog_r <= 1'b0;
    end else begin
      if (busy_r) begin
        tmr_r <= tmr_r - 1'b1;
        if (tmr_r == TW'(1)) begin
          busy_r <= 1'b0; // RQ13
          wait_r <= 1'b1;
          done_tog_r <= ~done_tog_r;
        end
      end else if (launch) begin
        busy_r <= 1'b1; // RQ13
        tmr_r <= TW'(PROG_CYCLES);
      end else if (!sync2_r[2]) begin
        wait_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idle_r <= 1'b1;
      standby_r <= 1'b1; // RQ6
    end else begin
      if (start_ev) begin
        idle_r <= 1'b0;
      end else if (stop_ev) begin
        idle_r <= 1'b1; // RQ3
      end
      standby_r <= idle_r && !busy_r && !launch && !start_ev; // RQ6
    end
  end

  assign standby = standby_r;
  assign prog_busy = busy_r;
endmodule // twe_dev

/* pkg/twe_pkg.sv */
// shared constants and types of the two-wire serial memory link
package twe_pkg;
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int DEV_TYPE_LSB = 4;
  localparam int RW_BIT_POS = 0;
  localparam int UPPER_WORD_ADDR_BIT_LOW_POS = 1;
  localparam int UPPER_WORD_ADDR_BIT_HIGH_POS = 3;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_CLOCK = 4'h8;
  localparam int DEFAULT_DENSITY_KBIT = 16;
  localparam int SMALL_DENSITY_MAX_KBIT = 2;
  localparam int SMALL_PAGE_BITS = 3;
  localparam int LARGE_PAGE_BITS = 4;
  localparam int WORDS_PER_KBIT = 128;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int SELF_TIMED_PROGRAM_TIME_MS = 10;
  localparam int SELF_TIMED_PROGRAM_CYCLES =
    SELF_TIMED_PROGRAM_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int SCL_MIN_PERIOD_NS = 2500;
  localparam int SCL_QUARTER_CYCLES =
    (SCL_MIN_PERIOD_NS / 4 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RECOVER_CLOCKS = 9;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WADDR, S_WDATA, S_READ} twe_dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_RECOV} twe_host_state_t;
endpackage

/* pkg/twe_if.sv */
// two-wire link between host and memory device, open-drain data resolved here
interface twe_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // pull-up: line low only while some end enables a low drive
  assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

/* logic/twe_host.sv */
// host end: makes the serial clock by division and moves one byte per command
module twe_host import twe_pkg::*; #(
  parameter int QUARTER = SCL_QUARTER_CYCLES
) (
  twe_if.host bus,
  input wire logic clock,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_ack,
  input wire logic cmd_recover,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  localparam int QW = $clog2(QUARTER + 1);

  if (QUARTER < 3) begin : g_bad_param
    $error("quarter period too short for the input synchroniser");
  end

  twe_host_state_t st_r;
  logic [1:0] ph_r;
  logic [QW-1:0] tick_r;
  logic [3:0] bit_r;
  logic [3:0] rec_r;
  logic scl_r;
  logic oe_n_r;
  logic [7:0] tx_r;
  logic rd_f_r;
  logic ack_f_r;
  logic stop_f_r;
  logic [7:0] rx_r;
  logic nack_r;
  logic ready_r;
  logic rsp_valid_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic tx_bit_n;

  // data bits first, ninth clock is the acknowledge slot
  assign tx_bit_n = (bit_r < ACK_CLOCK) ? (rd_f_r | tx_r[3'h7 - bit_r[2:0]]) :
    (rd_f_r ? ~ack_f_r : 1'b1); // RQ5

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= bus.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus sequencer, four quarter phases per step
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= H_IDLE;
      ph_r <= 2'h0;
      tick_r <= '0;
      bit_r <= 4'h0;
      rec_r <= 4'h0;
      scl_r <= 1'b1;
      oe_n_r <= 1'b1;
      tx_r <= 8'h00;
      rd_f_r <= 1'b0;
      ack_f_r <= 1'b0;
      stop_f_r <= 1'b0;
      rx_r <= 8'h00;
      nack_r <= 1'b0;
      ready_r <= 1'b1;
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      if (st_r == H_IDLE) begin
        if (cmd_valid && ready_r) begin
          ready_r <= 1'b0;
          tx_r <= cmd_data;
          rd_f_r <= cmd_read;
          ack_f_r <= cmd_ack;
          stop_f_r <= cmd_stop;
          ph_r <= 2'h0;
          tick_r <= '0;
          bit_r <= 4'h0;
          rec_r <= 4'h0;
          st_r <= cmd_recover ? H_RECOV : (cmd_start ? H_START : H_BIT); // RQ20
        end
      end else if (tick_r != '0) begin
        tick_r <= tick_r - 1'b1;
      end else begin
        tick_r <= QW'(QUARTER - 1);
        ph_r <= ph_r + 2'h1;
        case (st_r)
          H_START: begin
            case (ph_r)
              2'h0: oe_n_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: oe_n_r <= 1'b0; // RQ1 RQ2
              default: begin
                scl_r <= 1'b0;
                st_r <= H_BIT;
              end
            endcase
          end
          H_BIT: begin
            case (ph_r)
              2'h0: oe_n_r <= tx_bit_n; // RQ1 RQ10
              2'h1: scl_r <= 1'b1;
              2'h2: begin
                if (bit_r < ACK_CLOCK) begin
                  rx_r <= {rx_r[6:0], sda_s2_r};
                end else begin
                  nack_r <= sda_s2_r;
                end
              end
              default: begin
                scl_r <= 1'b0;
                bit_r <= bit_r + 4'h1;
                if (bit_r == ACK_CLOCK) begin
                  if (stop_f_r) begin
                    st_r <= H_STOP; // RQ12 RQ19
                  end else begin
                    st_r <= H_IDLE; // RQ14
                    ready_r <= 1'b1;
                    rsp_valid_r <= 1'b1;
                  end
                end
              end
            endcase
          end
          H_STOP: begin
            case (ph_r)
              2'h0: oe_n_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: oe_n_r <= 1'b1; // RQ1 RQ3
              default: begin
                st_r <= H_IDLE;
                ready_r <= 1'b1;
                rsp_valid_r <= 1'b1;
              end
            endcase
          end
          H_RECOV: begin
            case (ph_r)
              2'h0: oe_n_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: begin
                if (sda_s2_r) begin
                  oe_n_r <= 1'b0; // RQ7
                  st_r <= H_START;
                end
              end
              default: begin
                scl_r <= 1'b0;
                rec_r <= rec_r + 4'h1;
                if (rec_r == 4'(RECOVER_CLOCKS - 1)) begin
                  st_r <= H_START; // RQ7
                end
              end
            endcase
          end
          default: st_r <= H_IDLE;
        endcase
      end
    end
  end

  assign bus.scl = scl_r;
  assign bus.host_sda_oe_n = oe_n_r;
  assign bus.host_sda_o = 1'b0;
  assign cmd_ready = ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rx_r;
  assign rsp_nack = nack_r;
endmodule // twe_host

/* dv/twe_link_sva.sv */
// link checker: open-drain drive, data timing and program-cycle relations
module twe_link_sva #(
  parameter int PROG_CYCLES = 50
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic standby,
  input wire logic prog_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int busy_cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // length of the current program cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_r <= 0;
    end else if (prog_busy) begin
      busy_cnt_r <= busy_cnt_r + 1;
    end else begin
      busy_cnt_r <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence start_seq;
    scl && $past(scl) && $fell(sda);
  endsequence

  sequence stop_seq;
    scl && $past(scl) && $rose(sda);
  endsequence

  chk_dev_pull_low: assert property (!dev_sda_oe_n |-> !dev_sda_o && !sda)
    else $error("device drives data line high");
  chk_dev_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device data changed while clock high");
  chk_start_listen: assert property (start_seq |-> dev_sda_oe_n [*8])
    else $error("device drives line right after start");
  chk_stop_idle: assert property (stop_seq |-> ##[1:16] (standby || prog_busy))
    else $error("no standby or program after stop");
  chk_stop_release: assert property (stop_seq |-> dev_sda_oe_n [*4])
    else $error("device drives line after stop");
  chk_prog_quiet: assert property (prog_busy |-> dev_sda_oe_n)
    else $error("device answers during program cycle");
  chk_prog_standby: assert property (prog_busy |-> !standby)
    else $error("standby while program cycle runs");
  chk_prog_max: assert property (prog_busy |-> busy_cnt_r <= PROG_CYCLES)
    else $error("program cycle too long");
  chk_prog_min: assert property ($fell(prog_busy) |-> busy_cnt_r >= PROG_CYCLES - 1)
    else $error("program cycle too short");
  chk_standby_quiet: assert property (standby |-> dev_sda_oe_n)
    else $error("device drives line in standby");

  cover property (start_seq);
endmodule // twe_link_sva

/* dv/tb.sv */
// self-checking bench: host and device ends joined over the link
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PROG = 400;
  localparam int TD = 1;
  logic clock = 1'b0;
  logic nrst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_start = 1'b0;
  logic cmd_stop = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_ack = 1'b0;
  logic cmd_recover = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic standby;
  logic prog_busy;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] expm [16];
  logic [7:0] bad_addr [4] = '{8'hb0, 8'h80, 8'he0, 8'h20};
  logic nk;
  logic [7:0] rd;

  twe_if link();
  twe_host #(.QUARTER(3)) twe_host_inst (.bus(link.host), .clock(clock), .nrst(nrst),
    .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
    .cmd_ack(cmd_ack), .cmd_recover(cmd_recover), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  twe_dev #(.DENSITY_KBIT(16), .PROG_CYCLES(PROG)) twe_dev_inst (.bus(link.dev),
    .clock(clock), .nrst(nrst), .standby(standby), .prog_busy(prog_busy));
  twe_link_sva #(.PROG_CYCLES(PROG)) twe_link_sva_inst (.clock(clock), .nrst(nrst),
    .scl(link.scl), .sda(link.sda), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe_n(link.dev_sda_oe_n), .standby(standby), .prog_busy(prog_busy));

  always #50 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one command, held for one clock after ready is checked, then a bounded wait for its answer
  task automatic xfer(input logic st, input logic sp, input logic rdn, input logic ak,
                      input logic rc, input logic [7:0] d);
    int n;
    n = 0;
    `CHK(cmd_ready, 1'b1)
    cmd_valid = 1'b1;
    cmd_start = st;
    cmd_stop = sp;
    cmd_read = rdn;
    cmd_ack = ak;
    cmd_recover = rc;
    cmd_data = d;
    @(posedge clock);
    #TD;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(posedge clock);
      #TD;
      n++;
    end
    nk = rsp_nack;
    rd = rsp_data;
    if (n >= 2000) begin
      failures++;
      conclude();
    end
  endtask

  task automatic send(input logic st, input logic sp, input logic [7:0] d, input logic enk);
    xfer(st, sp, 1'b0, 1'b0, 1'b0, d);
    `CHK(nk, enk)
  endtask

  task automatic recv(input logic ak, input logic sp, input logic [7:0] exp);
    xfer(1'b0, sp, 1'b1, ak, 1'b0, 8'h00);
    `CHK(rd, exp)
  endtask

  task automatic wait_flag(input logic want_busy);
    int n;
    n = 0;
    while ((want_busy ? prog_busy : standby) !== 1'b1 && n < 32) begin
      @(posedge clock);
      #TD;
      n++;
    end
    `CHK(want_busy ? prog_busy : standby, 1'b1)
  endtask

  // address probe until the device answers again
  task automatic poll();
    int n;
    n = 0;
    nk = 1'b1;
    while (nk !== 1'b0 && n < 20) begin
      xfer(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'ha0);
      n++;
    end
    `CHK(nk, 1'b0)
  endtask

  task automatic write_byte(input logic [10:0] a, input logic [7:0] d);
    send(1'b1, 1'b0, {4'ha, a[10:8], 1'b0}, 1'b0);
    send(1'b0, 1'b0, a[7:0], 1'b0);
    send(1'b0, 1'b1, d, 1'b0);
    wait_flag(1'b1);
  endtask

  // dummy write of the word address, then repeated start for reading
  task automatic seek(input logic [10:0] a);
    send(1'b1, 1'b0, {4'ha, a[10:8], 1'b0}, 1'b0);
    send(1'b0, 1'b0, a[7:0], 1'b0);
    send(1'b1, 1'b0, {4'ha, a[10:8], 1'b1}, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #TD;
    nrst = 1'b0;
    repeat (4) @(posedge clock);
    #TD;
    nrst = 1'b1;
    @(posedge clock);
    #TD;
    `CHK(standby, 1'b1)
    write_byte(11'h305, 8'h3c);
    send(1'b1, 1'b1, 8'ha6, 1'b1);
    poll();
    seek(11'h305);
    recv(1'b0, 1'b1, 8'h3c);
    wait_flag(1'b0);
    for (int i = 0; i < 4; i++) begin
      send(1'b1, 1'b1, bad_addr[i], 1'b1);
    end
    send(1'b1, 1'b0, 8'ha6, 1'b0);
    send(1'b0, 1'b0, 8'h0e, 1'b0);
    for (int i = 0; i < 18; i++) begin
      send(1'b0, 1'(i == 17), 8'(64 + i), 1'b0);
      expm[(14 + i) % 16] = 8'(64 + i);
    end
    poll();
    seek(11'h300);
    for (int i = 0; i < 15; i++) begin
      recv(1'(i < 14), 1'(i == 14), expm[i]);
    end
    send(1'b1, 1'b0, 8'ha1, 1'b0);
    recv(1'b0, 1'b1, expm[15]);
    wait_flag(1'b0);
    write_byte(11'h7ff, 8'h5a);
    poll();
    write_byte(11'h000, 8'ha5);
    poll();
    seek(11'h7ff);
    recv(1'b1, 1'b0, 8'h5a);
    recv(1'b0, 1'b1, 8'ha5);
    seek(11'h7ff);
    recv(1'b1, 1'b0, 8'h5a);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'ha6);
    `CHK(nk, 1'b0)
    send(1'b0, 1'b0, 8'h05, 1'b0);
    send(1'b1, 1'b0, 8'ha7, 1'b0);
    recv(1'b0, 1'b1, expm[5]);
    wait_flag(1'b0);
    conclude();
  end
endmodule // tb
